// ---- hdl/eehst_pkg.sv ----
// Constants, enumerations and carrier structs for the two-wire EEPROM host.
// Assumes a 100 MHz system clock; the serial clock is derived from it.
package eehst_pkg;

  // Timing
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * SYS_PERIOD_NS - 1) / (4 * SYS_PERIOD_NS);
  localparam int TWR_MS = 5;
  localparam int TWR_CYCLES = TWR_MS * 1000000 / SYS_PERIOD_NS;

  // Device address type codes
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_EXT = 4'hB;

  // First word address patterns of the extra spaces
  localparam logic [7:0] ID_ADDR_HI = 8'h00;
  localparam logic [7:0] LOCK_ADDR_HI = 8'h04;
  localparam logic [7:0] SERIAL_ADDR_HI = 8'h08;

  // Fixed data bytes
  localparam logic [7:0] LOCK_DATA = 8'h02;
  localparam logic [7:0] QUERY_DATA = 8'hFF;

  // Sizes
  localparam logic [8:0] PAGE_BYTES = 9'h020;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [2:0] {
    K_WRITE, K_ID_WRITE, K_LOCK, K_LOCK_QUERY, K_READ_CUR, K_READ_RAND, K_ID_READ, K_SERIAL_READ
  } eehst_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SEND, ST_RECV, ST_LOAD, ST_STOP
  } eehst_state_t;

  typedef enum logic [2:0] {
    PH_DEV, PH_AHI, PH_ALO, PH_WDATA, PH_RDEV, PH_RDATA, PH_ABORT
  } eehst_phase_t;

  typedef struct packed {
    eehst_kind_t kind;
    logic [2:0] chip_sel;
    logic [12:0] addr;
    logic [7:0] count;
  } eehst_cmd_t;

  typedef struct packed {
    logic nack_err;
    logic timeout;
    logic locked;
  } eehst_result_t;

  typedef struct packed {
    eehst_state_t st;
    eehst_phase_t phase;
    eehst_cmd_t cmd;
    logic [7:0] remaining;
    logic [7:0] shift;
    logic [1:0] qtr;
    logic [6:0] div;
    logic [3:0] bit_cnt;
    logic ack;
    logic scl_low;
    logic sda_low;
    logic polling;
    logic need_poll;
    logic [19:0] poll_cnt;
    logic [2:0] sync;
    logic sda_filt;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    eehst_result_t result;
    logic wi;
  } eehst_regs_t;

  localparam eehst_regs_t REGS_RESET = '0;

endpackage : eehst_pkg

// ---- hdl/eehst_host.sv ----
// Two-wire bus host that drives a 64-Kbit serial EEPROM through its pins.
// Assumes pull-ups on both bus lines and user logic on clk_sys.
`timescale 1ns/100ps
module eehst_host
  import eehst_pkg::*;
#(
  parameter int TWR_CYCLES_P = TWR_CYCLES
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eehst_cmd_t cmd,
  // Write data stream
  input wire logic wr_data_valid,
  output logic wr_data_ready,
  input wire logic [7:0] wr_data,
  // Read data and completion
  output logic rd_data_valid,
  output logic [7:0] rd_data,
  output logic done,
  output eehst_result_t result,
  output logic busy,
  // Write protection request
  input wire logic write_protect,
  // Bus pins
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic write_inhibit_pin
);

  eehst_regs_t q;
  eehst_regs_t n;
  logic tick;

  // Array space or the extended identification, lock and serial spaces
  function automatic logic is_ext(input eehst_kind_t k);
    is_ext = !(k inside {K_WRITE, K_READ_CUR, K_READ_RAND});
  endfunction : is_ext

  function automatic logic is_write(input eehst_kind_t k);
    is_write = k inside {K_WRITE, K_ID_WRITE, K_LOCK, K_LOCK_QUERY};
  endfunction : is_write

  // Byte to shift out for a phase
  function automatic logic [7:0] pick_byte(input eehst_cmd_t c, input eehst_phase_t p, input logic poll);
    logic [3:0] code;
    logic rw;
    code = is_ext(c.kind) ? TYPE_EXT : TYPE_ARRAY;
    rw = (p == PH_RDEV) || (c.kind == K_READ_CUR && !poll);
    pick_byte = 8'h00;
    case (p)
      PH_DEV, PH_RDEV: pick_byte = {code, c.chip_sel, rw};
      PH_AHI:
      begin
        case (c.kind)
          K_ID_WRITE, K_ID_READ: pick_byte = ID_ADDR_HI;
          K_LOCK: pick_byte = LOCK_ADDR_HI;
          K_LOCK_QUERY: pick_byte = ID_ADDR_HI;
          K_SERIAL_READ: pick_byte = SERIAL_ADDR_HI;
          default: pick_byte = {3'h0, c.addr[12:8]};
        endcase
      end
      PH_ALO:
      begin
        case (c.kind)
          K_ID_WRITE, K_ID_READ, K_LOCK_QUERY: pick_byte = {3'h0, c.addr[4:0]};
          K_LOCK: pick_byte = 8'h00;
          K_SERIAL_READ: pick_byte = {4'h0, c.addr[3:0]};
          default: pick_byte = c.addr[7:0];
        endcase
      end
      PH_WDATA: pick_byte = (c.kind == K_LOCK) ? LOCK_DATA : QUERY_DATA;
      default: pick_byte = 8'h00;
    endcase
  endfunction : pick_byte

  // Byte count actually run for a command
  function automatic logic [7:0] load_count(input eehst_cmd_t c);
    logic [8:0] room;
    logic [8:0] want;
    room = PAGE_BYTES - {4'h0, c.addr[4:0]};
    want = (c.count == 8'h00) ? 9'h001 : {1'b0, c.count};
    load_count = want[7:0];
    case (c.kind)
      K_WRITE, K_ID_WRITE: if (want > PAGE_BYTES) load_count = PAGE_BYTES[7:0];
      K_ID_READ: if (want > room) load_count = room[7:0];
      K_LOCK, K_LOCK_QUERY: load_count = 8'h01;
      default: load_count = want[7:0];
    endcase
  endfunction : load_count

  assign tick = (q.div == 7'(QTR_CYCLES - 1));

  always_comb
  begin
    n = q;
    n.rd_valid = 1'b0;
    n.done = 1'b0;
    n.sync = {q.sync[1:0], sda_in};
    if (q.sync[2] == q.sync[1])
      n.sda_filt = q.sync[2];
    n.wi = write_protect;
    n.div = tick ? 7'h00 : 7'(q.div + 7'h01);
    if (q.polling || q.need_poll)
      n.poll_cnt = 20'(q.poll_cnt + 20'h00001);
    if (tick)
      n.qtr = 2'(q.qtr + 2'h1);
    case (q.st)
      ST_IDLE:
      begin
        n.div = 7'h00;
        n.qtr = 2'h0;
        if (cmd_valid)
        begin
          n.cmd = cmd;
          n.remaining = load_count(cmd);
          n.phase = PH_DEV;
          n.polling = 1'b0;
          n.need_poll = 1'b0;
          n.result = '0;
          n.st = ST_START;
        end
      end
      ST_START:
      begin
        if (tick)
        begin
          case (q.qtr)
            2'h0: n.sda_low = 1'b0;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b1;
            default:
            begin
              n.scl_low = 1'b1;
              n.bit_cnt = 4'h0;
              if (q.phase == PH_ABORT)
                n.st = ST_STOP;
              else
              begin
                n.shift = pick_byte(q.cmd, q.phase, q.polling);
                n.st = ST_SEND;
              end
            end
          endcase
        end
      end
      ST_SEND:
      begin
        if (tick)
        begin
          case (q.qtr)
            2'h0: n.sda_low = (q.bit_cnt < LAST_BIT) ? !q.shift[7] : 1'b0;
            2'h1: n.scl_low = 1'b0;
            2'h2: if (q.bit_cnt == LAST_BIT) n.ack = !q.sda_filt;
            default:
            begin
              n.scl_low = 1'b1;
              n.bit_cnt = 4'(q.bit_cnt + 4'h1);
              n.shift = {q.shift[6:0], 1'b0};
              if (q.bit_cnt == LAST_BIT)
              begin
                n.bit_cnt = 4'h0;
                n.st = ST_STOP;
                case (q.phase)
                  PH_DEV:
                  begin
                    if (q.polling)
                    begin
                      if (!q.ack && q.poll_cnt >= 20'(TWR_CYCLES_P))
                      begin
                        n.result.timeout = 1'b1;
                        n.polling = 1'b0;
                      end
                      else if (!q.ack)
                      begin
                        n.need_poll = 1'b1;
                        n.polling = 1'b0;
                      end
                      else
                        n.polling = 1'b0;
                    end
                    else if (!q.ack)
                      n.result.nack_err = 1'b1;
                    else if (q.cmd.kind == K_READ_CUR)
                    begin
                      n.phase = PH_RDATA;
                      n.st = ST_RECV;
                    end
                    else
                    begin
                      n.phase = PH_AHI;
                      n.shift = pick_byte(q.cmd, PH_AHI, 1'b0);
                      n.st = ST_SEND;
                    end
                  end
                  PH_AHI:
                  begin
                    n.phase = PH_ALO;
                    n.shift = pick_byte(q.cmd, PH_ALO, 1'b0);
                    n.st = q.ack ? ST_SEND : ST_STOP;
                    n.result.nack_err = !q.ack;
                  end
                  PH_ALO:
                  begin
                    n.result.nack_err = !q.ack;
                    if (q.ack && is_write(q.cmd.kind))
                    begin
                      n.phase = PH_WDATA;
                      n.shift = pick_byte(q.cmd, PH_WDATA, 1'b0);
                      n.st = (q.cmd.kind inside {K_WRITE, K_ID_WRITE}) ? ST_LOAD : ST_SEND;
                    end
                    else if (q.ack)
                    begin
                      n.phase = PH_RDEV;
                      n.st = ST_START;
                    end
                  end
                  PH_RDEV:
                  begin
                    n.phase = PH_RDATA;
                    n.result.nack_err = !q.ack;
                    n.st = q.ack ? ST_RECV : ST_STOP;
                  end
                  PH_WDATA:
                  begin
                    n.remaining = 8'(q.remaining - 8'h01);
                    if (q.cmd.kind == K_LOCK_QUERY)
                    begin
                      n.result.locked = !q.ack;
                      n.phase = PH_ABORT;
                      n.st = ST_START;
                    end
                    else if (!q.ack)
                      n.result.nack_err = 1'b1;
                    else if (q.remaining == 8'h01)
                    begin
                      n.need_poll = 1'b1;
                      n.poll_cnt = 20'h00000;
                    end
                    else
                      n.st = ST_LOAD;
                  end
                  default: n.st = ST_STOP;
                endcase
              end
            end
          endcase
        end
      end
      ST_LOAD:
      begin
        n.div = 7'h00;
        n.qtr = 2'h0;
        if (wr_data_valid)
        begin
          n.shift = wr_data;
          n.bit_cnt = 4'h0;
          n.st = ST_SEND;
        end
      end
      ST_RECV:
      begin
        if (tick)
        begin
          case (q.qtr)
            2'h0: n.sda_low = (q.bit_cnt == LAST_BIT) && (q.remaining > 8'h01);
            2'h1: n.scl_low = 1'b0;
            2'h2: if (q.bit_cnt < LAST_BIT) n.shift = {q.shift[6:0], q.sda_filt};
            default:
            begin
              n.scl_low = 1'b1;
              n.bit_cnt = 4'(q.bit_cnt + 4'h1);
              if (q.bit_cnt == LAST_BIT)
              begin
                n.bit_cnt = 4'h0;
                n.rd_data = q.shift;
                n.rd_valid = 1'b1;
                n.remaining = 8'(q.remaining - 8'h01);
                if (q.remaining == 8'h01)
                  n.st = ST_STOP;
              end
            end
          endcase
        end
      end
      ST_STOP:
      begin
        if (tick)
        begin
          case (q.qtr)
            2'h0: n.sda_low = 1'b1;
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b0;
            default:
            begin
              if (q.need_poll)
              begin
                n.need_poll = 1'b0;
                n.polling = 1'b1;
                n.phase = PH_DEV;
                n.st = ST_START;
              end
              else
              begin
                n.done = 1'b1;
                n.st = ST_IDLE;
              end
            end
          endcase
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      q <= REGS_RESET;
    else
      q <= n;
  end

  assign cmd_ready = (q.st == ST_IDLE);
  assign wr_data_ready = (q.st == ST_LOAD);
  assign busy = (q.st != ST_IDLE);
  assign rd_data_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign done = q.done;
  assign result = q.result;
  assign scl_out = 1'b0;
  assign scl_oe = q.scl_low;
  assign sda_out = 1'b0;
  assign sda_oe = q.sda_low;
  assign write_inhibit_pin = q.wi;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence start_ends;
    q.st == ST_START && tick && q.qtr == 2'h3 && q.phase != PH_ABORT;
  endsequence

  sequence ninth_bit_driven;
    q.bit_cnt == LAST_BIT && q.qtr != 2'h0;
  endsequence

  dev_type_code_a: assert property (start_ends and (q.phase == PH_DEV || q.phase == PH_RDEV)
    |=> q.shift[7:4] == (is_ext(q.cmd.kind) ? TYPE_EXT : TYPE_ARRAY))
    else $error("device type code wrong");
  chip_select_a: assert property (start_ends |=> q.shift[3:1] == q.cmd.chip_sel)
    else $error("chip select bits wrong");
  read_select_a: assert property (start_ends and q.phase == PH_RDEV |=> q.shift[0])
    else $error("read bit not set");
  lock_byte_a: assert property ((q.st == ST_SEND && q.phase == PH_WDATA && q.cmd.kind == K_LOCK && q.bit_cnt == 4'h0)
    |-> q.shift == LOCK_DATA)
    else $error("lock data byte wrong");
  data_clock_low_a: assert property (($changed(q.sda_low) && !(q.st inside {ST_START, ST_STOP}))
    |-> q.scl_low && $past(q.scl_low))
    else $error("data moved while clock high");
  ack_release_a: assert property ((q.st == ST_SEND) and ninth_bit_driven |-> !q.sda_low)
    else $error("data line held during device ack");
  host_ack_a: assert property ((q.st == ST_RECV) and ninth_bit_driven |-> q.sda_low == (q.remaining > 8'h01))
    else $error("host ack level wrong");
  id_read_bound_a: assert property ((q.st == ST_IDLE && cmd_valid && cmd.kind == K_ID_READ)
    |=> ({4'h0, q.cmd.addr[4:0]} + {1'b0, q.remaining}) <= PAGE_BYTES)
    else $error("identification_page read crosses page");
  poll_bound_a: assert property ((q.st == ST_SEND && q.polling && !q.ack && tick && q.qtr == 2'h3
    && q.bit_cnt == LAST_BIT && q.poll_cnt >= 20'(TWR_CYCLES_P)) |=> q.result.timeout)
    else $error("poll not bounded");

endmodule : eehst_host

// ---- verif/eehst_eeprom_model.sv ----
// Behavioural serial EEPROM standing on the far side of the two-wire bus.
// Assumes pull-ups on both lines; pulls data low only through sda_oe.
`timescale 1ns/100ps
module eehst_eeprom_model (
  // Bus and pins
  input wire logic scl,
  input wire logic sda,
  input wire logic [2:0] cs_pins,
  input wire logic write_inhibit_pin,
  // Programming time in ns
  input wire logic [31:0] prog_ns,
  // Data line pull-down
  output logic sda_oe
);
  logic [7:0] mem [0:8191];
  logic [7:0] id_pg [0:31];
  logic [7:0] sn [0:15];
  logic [13:0] pa [$];
  logic [7:0] pd [$];
  logic [12:0] ptr;
  logic [7:0] sh, ahi, rd;
  logic [3:0] bitn;
  logic [2:0] ph;
  logic ack, ext, busy, locked, lk_pend;

  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = i[7:0] ^ {3'h0, i[12:8]};
    for (int i = 0; i < 32; i++)
      id_pg[i] = 8'hFF;
    for (int i = 0; i < 16; i++)
      sn[i] = 8'hC0 + i[7:0];
    {ptr, sh, ahi, rd, bitn, ph, ack, ext, busy, locked, lk_pend, sda_oe} = '0;
  end

  // Next read byte and pointer step
  task load;
    rd = !ext ? mem[ptr] : (ahi[3] ? sn[ptr[3:0]] : id_pg[ptr[4:0]]);
    if (ext && ahi[3])
      ptr[3:0] = ptr[3:0] + 4'h1;
    else if (ext)
      ptr[4:0] = ptr[4:0] + 5'h01;
    else
      ptr = ptr + 13'h0001;
  endtask : load

  // Received byte handling
  task take_byte;
    ack = 1'b1;
    case (ph)
      3'h1:
      begin
        ext = sh[4];
        ack = sh[7:5] == 3'h5 && sh[3:1] == cs_pins && !busy;
        ph = !ack ? 3'h0 : (sh[0] ? 3'h5 : 3'h2);
      end
      3'h2:
      begin
        ahi = sh;
        ph = 3'h3;
      end
      3'h3:
      begin
        ptr = {ahi[4:0], sh};
        ph = 3'h4;
      end
      3'h4:
      begin
        if (ext && ahi[2])
          lk_pend = sh[1];
        else if (ext)
        begin
          ack = !locked;
          if (!locked)
          begin
            pa.push_back({1'b1, 8'h00, ptr[4:0]});
            pd.push_back(sh);
          end
        end
        else if (!write_inhibit_pin)
        begin
          pa.push_back({1'b0, ptr});
          pd.push_back(sh);
        end
        ptr[4:0] = ptr[4:0] + 5'h01;
      end
      default:
        ack = 1'b0;
    endcase
  endtask : take_byte

  // Start clears pending writes
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      ph = 3'h1;
      bitn = 4'h0;
      pa.delete();
      pd.delete();
      lk_pend = 1'b0;
    end

  // Stop commits and starts programming
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      ph = 3'h0;
      if (pa.size() > 0 || lk_pend)
      begin
        foreach (pa[i])
          if (pa[i][13])
            id_pg[pa[i][4:0]] = pd[i];
          else
            mem[pa[i][12:0]] = pd[i];
        if (lk_pend)
          locked = 1'b1;
        busy = 1'b1;
        busy <= #(prog_ns) 1'b0;
        pa.delete();
        pd.delete();
        lk_pend = 1'b0;
      end
    end

  // Bit sampling on clock rise
  always @(posedge scl)
    if (ph != 3'h0)
    begin
      if (bitn == 4'h8)
      begin
        bitn = 4'h0;
        if (ph == 3'h5 && sda)
          ph = 3'h0;
        else if (ph == 3'h5)
          load();
      end
      else
      begin
        sh = {sh[6:0], sda};
        bitn = bitn + 4'h1;
        if (bitn == 4'h8)
          take_byte();
      end
    end

  // Change drive only on clock fall, holding it through clock high
  always @(negedge scl)
    sda_oe = (bitn == 4'h8) ? ack : (ph == 3'h5 && bitn < 4'h8 && !rd[7 - bitn]);
endmodule : eehst_eeprom_model

// ---- verif/tb.sv ----
// Self-checking bench for the two-wire EEPROM host.
// Assumes the behavioural EEPROM model on the far side of the bus.
`timescale 1ns/100ps
module tb;
  import eehst_pkg::*;
  localparam logic [2:0] CS = 3'h5;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  eehst_cmd_t cmd = '0;
  logic wr_data_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic write_protect = 1'b0;
  logic [31:0] prog_ns = 32'h00002710;
  logic cmd_ready, wr_data_ready, rd_data_valid, done, busy, scl_out, scl_oe;
  logic sda_out, sda_oe, write_inhibit_pin, dev_oe, scl, sda;
  logic [7:0] rd_data;
  eehst_result_t result, res;
  logic [7:0] wq [0:31];
  logic [7:0] rq [0:31];
  logic [7:0] nrd;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  assign scl = scl_oe ? scl_out : 1'b1;
  assign sda = sda_oe ? sda_out : (dev_oe ? 1'b0 : 1'b1);

  always #5 clk_sys = ~clk_sys;

  eehst_host #(.TWR_CYCLES_P(6000)) dut_u (
    .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wr_data_valid(wr_data_valid), .wr_data_ready(wr_data_ready), .wr_data(wr_data),
    .rd_data_valid(rd_data_valid), .rd_data(rd_data), .done(done), .result(result), .busy(busy),
    .write_protect(write_protect), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_inhibit_pin(write_inhibit_pin)
  );

  eehst_eeprom_model mem_u (
    .scl(scl), .sda(sda), .cs_pins(CS), .write_inhibit_pin(write_inhibit_pin),
    .prog_ns(prog_ns), .sda_oe(dev_oe)
  );

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      bad_count++;
      results();
    end
  end

  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction : pat

  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One command, feeding write bytes and collecting read bytes
  task automatic run(input eehst_kind_t k, input logic [12:0] a, input logic [7:0] n,
                     input logic [2:0] cs = CS);
    int wi;
    logic took;
    wi = 0;
    nrd = 8'h00;
    took = 1'b0;
    @(negedge clk_sys);
    cmd = '{k, cs, a, n};
    cmd_valid = 1'b1;
    wr_data = wq[0];
    wr_data_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    check({6'h00, busy, cmd_ready}, 8'h02);
    for (int t = 0; t < 90000 && done !== 1'b1; t++)
    begin
      @(negedge clk_sys);
      if (took)
      begin
        wi++;
        wr_data = wq[wi];
      end
      took = wr_data_ready === 1'b1;
      if (rd_data_valid === 1'b1)
      begin
        rq[nrd] = rd_data;
        nrd++;
      end
    end
    wr_data_valid = 1'b0;
    res = result;
    check({7'h00, done}, 8'h01);
    check({6'h00, busy, cmd_ready}, 8'h01);
  endtask : run

  task page_write;
    wq[0] = 8'h11;
    wq[1] = 8'h22;
    run(K_WRITE, 13'h003F, 8'h02);
    check({5'h00, res}, 8'h00);
    run(K_READ_RAND, 13'h0020, 8'h01);
    check(rq[0], 8'h22);
    run(K_READ_CUR, 13'h0000, 8'h02);
    check(rq[0], pat(13'h0021));
    check(rq[1], pat(13'h0022));
    run(K_READ_RAND, 13'h003F, 8'h01);
    check(rq[0], 8'h11);
  endtask : page_write

  task inhibit;
    write_protect = 1'b1;
    wq[0] = 8'h77;
    run(K_WRITE, 13'h0100, 8'h01);
    check({7'h00, write_inhibit_pin}, 8'h01);
    check({5'h00, res}, 8'h00);
    write_protect = 1'b0;
    run(K_READ_RAND, 13'h0100, 8'h01);
    check(rq[0], pat(13'h0100));
  endtask : inhibit

  task wrong_select;
    run(K_READ_CUR, 13'h0000, 8'h01, 3'h2);
    check({7'h00, res.nack_err}, 8'h01);
    check(nrd, 8'h00);
  endtask : wrong_select

  task identification_page;
    wq[0] = 8'h3C;
    run(K_ID_WRITE, 13'h001F, 8'h01);
    check({5'h00, res}, 8'h00);
    run(K_ID_READ, 13'h001F, 8'h01);
    check(rq[0], 8'h3C);
    run(K_LOCK_QUERY, 13'h0000, 8'h01);
    check({7'h00, res.locked}, 8'h00);
    run(K_LOCK, 13'h0000, 8'h01);
    check({5'h00, res}, 8'h00);
    run(K_LOCK_QUERY, 13'h0000, 8'h01);
    check({7'h00, res.locked}, 8'h01);
    wq[0] = 8'h55;
    run(K_ID_WRITE, 13'h001F, 8'h01);
    check({7'h00, res.nack_err}, 8'h01);
  endtask : identification_page

  task serial_read;
    run(K_SERIAL_READ, 13'h000F, 8'h02);
    check(rq[0], 8'hCF);
    check(rq[1], 8'hC0);
  endtask : serial_read

  task slow_write;
    prog_ns = 32'h00030D40;
    wq[0] = 8'h99;
    run(K_WRITE, 13'h0200, 8'h01);
    check({7'h00, res.timeout}, 8'h01);
  endtask : slow_write

  task results;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  initial
  begin
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    page_write();
    inhibit();
    wrong_select();
    identification_page();
    serial_read();
    slow_write();
    results();
  end
endmodule : tb
